/* File: rtl/ulc_core.sv */
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "ulc_params.svh"
// Function
// - Bits 31 to 8 read zero; writes there do nothing.
// - Bit 7 shows live J state on the lines.
// - Bit 6 shows live single-ended zero on the lines.
// - Device mode: SETUP sets bit 5, halting processing until cleared.
// - Host mode: bit 5 high while a token executes.
// - Bit 4 written one drives bus reset; zero ends it.
// - Bit 3 enables host role; any change resets host logic.
// - Bit 2 high drives resume signaling, low drives none.
// - Host mode: clearing resume appends a low-speed EOP.
module ulc_core #(
   parameter int EOP_CYC = `ULC_EOP_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire logic live_j_line_i,
   input wire logic live_se0_i,
   input wire logic setup_token_i,
   input wire logic token_start_i,
   input wire logic token_done_i,
   output logic packet_processing_disable_o,
   output logic token_in_progress_o,
   output logic bus_reset_generate_o,
   output logic host_role_enable_o,
   output logic host_logic_reset_o,
   output logic resume_drive_o,
   output logic eop_drive_o,
   output logic pingpong_pointer_reset_o,
   output logic device_module_enable_o,
   output logic frame_start_generation_enable_o,
   output logic irq_o
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic pkt_dis;
      logic tok_busy;
      logic brst;
      logic host;
      logic resume;
      logic pprst;
      logic en;
      ulc_pkg::ulc_sig_type sig;
      logic [7:0] eop_cnt;
      logic host_rst;
      logic [3:0] mask;
      logic [31:0] dat;
      logic ack;
      logic err;
   } ulc_state_type;
   ulc_state_type r;
   ulc_state_type next_r;
   ulc_ev_if ev_bus();
   logic acc;
   logic wr;
   logic [7:0] ctrl_rd;
   logic [7:0] wdat;
   logic lane0;
   assign acc = wb_cyc_i & wb_stb_i & ~r.ack & ~r.err;
   assign wr = acc & wb_we_i;
   assign lane0 = wb_sel_i[0];
   assign wdat = wb_dat_i[7:0];
   // Live line bits are never kept in control state, only sampled into read data
   assign ctrl_rd = {live_j_line_i, live_se0_i,
      (r.host ? r.tok_busy : r.pkt_dis), r.brst, r.host, r.resume,
      r.pprst, r.en};
   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_r = r;
      next_r.ack = 1'b0;
      next_r.err = 1'b0;
      next_r.host_rst = 1'b0;
      ev_bus.ev = 4'h0;
      ev_bus.clr = 4'h0;
      ev_bus.mask = r.mask;
      if (acc) begin
         unique case (wb_adr_i)
            `ULC_OFS_CTRL: begin
               next_r.dat = {24'h000000, ctrl_rd};
               if (wr && lane0) begin
                  next_r.brst = wdat[`ULC_BIT_BRST];
                  next_r.host = wdat[`ULC_BIT_HOST];
                  next_r.resume = wdat[`ULC_BIT_RESUME];
                  next_r.pprst = wdat[`ULC_BIT_PPRST];
                  next_r.en = wdat[`ULC_BIT_EN];
                  if (!r.host) begin
                     next_r.pkt_dis = wdat[`ULC_BIT_PKT];
                  end
               end
               next_r.ack = 1'b1;
            end
            `ULC_OFS_STAT: begin
               next_r.dat = {28'h0000000, ev_bus.stat};
               if (wr && lane0) begin
                  ev_bus.clr = wdat[3:0];
               end
               next_r.ack = 1'b1;
            end
            `ULC_OFS_MASK: begin
               next_r.dat = {28'h0000000, r.mask};
               if (wr && lane0) begin
                  next_r.mask = wdat[3:0];
               end
               next_r.ack = 1'b1;
            end
            default: begin
               next_r.dat = 32'h00000000;
               next_r.err = 1'b1;
            end
         endcase
      end
      // Host role change clears host engine
      if (next_r.host != r.host) begin
         next_r.host_rst = 1'b1;
         next_r.tok_busy = 1'b0;
         next_r.sig = ulc_pkg::ULC_IDLE;
         next_r.eop_cnt = 8'h00;
         ev_bus.ev[`ULC_EV_ROLE] = 1'b1;
      end else if (r.host) begin
         if (token_start_i) begin
            next_r.tok_busy = 1'b1;
         end else if (token_done_i && r.tok_busy) begin
            next_r.tok_busy = 1'b0;
            ev_bus.ev[`ULC_EV_TOKDONE] = 1'b1;
         end
      end else if (setup_token_i) begin
         next_r.pkt_dis = 1'b1;
         ev_bus.ev[`ULC_EV_SETUP] = 1'b1;
      end
      // Resume then low-speed EOP in host role
      unique case (r.sig)
         ulc_pkg::ULC_IDLE: begin
            // Starts off the stored bit, one cycle after the write lands
            if (r.resume && !next_r.host_rst) begin
               next_r.sig = ulc_pkg::ULC_RESUME;
            end
         end
         ulc_pkg::ULC_RESUME: begin
            if (!r.resume) begin
               if (r.host) begin
                  next_r.sig = ulc_pkg::ULC_EOP;
                  next_r.eop_cnt = 8'(EOP_CYC - 1);
               end else begin
                  next_r.sig = ulc_pkg::ULC_IDLE;
               end
            end
         end
         ulc_pkg::ULC_EOP: begin
            if (r.eop_cnt == 8'h00) begin
               next_r.sig = ulc_pkg::ULC_IDLE;
               ev_bus.ev[`ULC_EV_EOP] = 1'b1;
            end else begin
               next_r.eop_cnt = r.eop_cnt - 8'h01;
            end
         end
         default: begin
            next_r.sig = ulc_pkg::ULC_IDLE;
         end
      endcase
      if (next_r.host_rst) begin
         next_r.sig = ulc_pkg::ULC_IDLE;
      end
   end
   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
   ulc_events u_events (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .e(ev_bus.evu)
   );
   // ****************************************
   // Outputs, all from flops
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(ev_bus.stat & r.mask);
      end
   end
   assign wb_dat_o = r.dat;
   assign wb_ack_o = r.ack;
   assign wb_err_o = r.err;
   assign packet_processing_disable_o = r.pkt_dis & ~r.host;
   assign token_in_progress_o = r.tok_busy;
   assign bus_reset_generate_o = r.brst;
   assign host_role_enable_o = r.host;
   assign host_logic_reset_o = r.host_rst;
   assign resume_drive_o = r.sig == ulc_pkg::ULC_RESUME;
   assign eop_drive_o = r.sig == ulc_pkg::ULC_EOP;
   assign pingpong_pointer_reset_o = r.pprst;
   assign device_module_enable_o = r.en & ~r.host;
   assign frame_start_generation_enable_o = r.en & r.host;
   // ****************************************
   // Checks
   // ****************************************
   sequence s_resume_drop;
      r.sig == ulc_pkg::ULC_RESUME && !r.resume && r.host;
   endsequence
   a_eop_append: assert property (@(posedge clk_i) disable iff (rst_i)
      s_resume_drop |=> eop_drive_o)
      else $error("no EOP after resume in host role");
   a_role_reset: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(r.host) |-> $past(next_r.host_rst) && !r.tok_busy)
      else $error("role change without host reset");
   a_setup_halt: assert property (@(posedge clk_i) disable iff (rst_i)
      (!r.host && setup_token_i && !wr) ##1 !$changed(r.host)
      |-> packet_processing_disable_o)
      else $error("SETUP did not halt processing");
   a_tok_busy: assert property (@(posedge clk_i) disable iff (rst_i)
      (r.host && token_start_i && !wr) |=> token_in_progress_o)
      else $error("token busy not raised");
   a_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("upper bits not zero");
   a_brst_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && lane0 && wb_adr_i == `ULC_OFS_CTRL)
      |=> bus_reset_generate_o == $past(wdat[`ULC_BIT_BRST]))
      else $error("bus reset does not follow write");
   a_resume_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      !r.resume && !resume_drive_o |=> !resume_drive_o)
      else $error("resume driven while disabled");
   a_live_lines: assert property (@(posedge clk_i) disable iff (rst_i)
      (acc && !wb_we_i && wb_adr_i == `ULC_OFS_CTRL)
      |=> wb_dat_o[7:6] == $past({live_j_line_i, live_se0_i}))
      else $error("live line bits wrong");
   a_ctrl_rst: assert property (@(posedge clk_i)
      rst_i |=> {r.brst, r.host, r.resume, r.pprst, r.en} == 5'h00)
      else $error("control not cleared by reset");
   a_pprst: assert property (@(posedge clk_i) disable iff (rst_i)
      pingpong_pointer_reset_o == r.pprst
      && (r.host || !frame_start_generation_enable_o))
      else $error("pointer reset or enable wrong");
endmodule

/* File: rtl/ulc_params.svh */
`ifndef ULC_PARAMS_SVH
`define ULC_PARAMS_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define ULC_OFS_CTRL 4'h0
`define ULC_OFS_STAT 4'h4
`define ULC_OFS_MASK 4'h8
// ****************************************
// Control field positions
// ****************************************
`define ULC_BIT_JLINE 7
`define ULC_BIT_SE0 6
`define ULC_BIT_PKT 5
`define ULC_BIT_BRST 4
`define ULC_BIT_HOST 3
`define ULC_BIT_RESUME 2
`define ULC_BIT_PPRST 1
`define ULC_BIT_EN 0
// ****************************************
// Event bit positions and reset values
// ****************************************
`define ULC_EV_SETUP 0
`define ULC_EV_TOKDONE 1
`define ULC_EV_ROLE 2
`define ULC_EV_EOP 3
`define ULC_CTRL_RST 6'h00
`define ULC_EV_RST 4'h0
// ****************************************
// Timing
// ****************************************
`define ULC_CLK_HZ 40000000
`define ULC_EOP_NS 1330
`define ULC_EOP_CYC ((`ULC_EOP_NS * 40) / 1000)
`endif

/* File: rtl/ulc_pkg.sv */
package ulc_pkg;
   typedef enum logic [1:0] {
      ULC_IDLE = 2'b00,
      ULC_RESUME = 2'b01,
      ULC_EOP = 2'b10
   } ulc_sig_type;
endpackage

/* File: rtl/ulc_ev_if.sv */
`timescale 1ns/1ps
interface ulc_ev_if;
   logic [3:0] ev;
   logic [3:0] clr;
   logic [3:0] mask;
   logic [3:0] stat;
   logic irq;
   modport core(output ev, output clr, output mask, input stat, input irq);
   modport evu(input ev, input clr, input mask, output stat, output irq);
endinterface

/* File: rtl/ulc_events.sv */
`timescale 1ns/1ps
`include "ulc_params.svh"
module ulc_events (
   input wire logic clk_i,
   input wire logic rst_i,
   ulc_ev_if.evu e
);
   typedef struct packed {
      logic [3:0] stat;
      logic irq;
   } ulc_evs_type;
   ulc_evs_type r;
   ulc_evs_type next_r;
   // ****************************************
   // Sticky bits, set beats clear
   // ****************************************
   always_comb begin
      next_r = r;
      next_r.stat = (r.stat & ~e.clr) | e.ev;
      next_r.irq = |(next_r.stat & e.mask);
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
   assign e.stat = r.stat;
   assign e.irq = r.irq;
   a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
      |e.ev |-> ##1 ((e.stat & $past(e.ev)) == $past(e.ev)))
      else $error("event lost against clear");
endmodule

/* File: verification/ulc_usb_partner.sv */
`timescale 1ns/1ps
// ****************************************
// Far-side bus partner
// ****************************************
module ulc_usb_partner (
   input wire logic clk_i,
   output logic j_o,
   output logic se0_o,
   output logic setup_o,
   output logic tstart_o,
   output logic tdone_o
);
   initial begin
      j_o = 1'b0;
      se0_o = 1'b0;
      setup_o = 1'b0;
      tstart_o = 1'b0;
      tdone_o = 1'b0;
   end
   // Line states move only just after an edge
   task automatic lines(input logic j, input logic s);
      @(posedge clk_i);
      j_o <= j;
      se0_o <= s;
   endtask
   // Event pulses: 0 setup, 1 token start, 2 token done
   task automatic pulse(input int k);
      @(posedge clk_i);
      setup_o <= (k == 0);
      tstart_o <= (k == 1);
      tdone_o <= (k == 2);
      @(posedge clk_i);
      setup_o <= 1'b0;
      tstart_o <= 1'b0;
      tdone_o <= 1'b0;
   endtask
endmodule

/* File: verification/usb_control_register_logic_bench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module usb_control_register_logic_bench;
   localparam int EOP = 4;
   // Stands in for the long wake-up hold, kept short for run time
   localparam int RES_HOLD = 40;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [3:0] sel = 4'hF;
   logic [3:0] sel_v = 4'hF;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic [31:0] rdat;
   logic ack, err, j, se0, su, ts, td;
   logic pkt, busy, brst, hen, hlr, res, eop, pp, den, sof, irq;
   logic [31:0] q;
   logic e;
   int n_fail = 0;
   int checked = 0;
   int n_hlr = 0;
   int n_eop = 0;
   int k;
   always #12.5 clk_i = ~clk_i;
   ulc_core #(.EOP_CYC(EOP)) ulc_core_inst (.clk_i(clk_i), .rst_i(rst_i),
      .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
      .wb_err_o(err), .live_j_line_i(j), .live_se0_i(se0),
      .setup_token_i(su), .token_start_i(ts), .token_done_i(td),
      .packet_processing_disable_o(pkt), .token_in_progress_o(busy),
      .bus_reset_generate_o(brst), .host_role_enable_o(hen),
      .host_logic_reset_o(hlr), .resume_drive_o(res), .eop_drive_o(eop),
      .pingpong_pointer_reset_o(pp), .device_module_enable_o(den),
      .frame_start_generation_enable_o(sof), .irq_o(irq));
   ulc_usb_partner ulc_usb_partner_inst (.clk_i(clk_i), .j_o(j),
      .se0_o(se0), .setup_o(su), .tstart_o(ts), .tdone_o(td));
   // Counted mid-cycle so the launching edge cannot race the count
   always @(negedge clk_i) begin
      if (hlr === 1'b1) n_hlr++;
      if (eop === 1'b1) n_eop++;
   end
   // ****************************************
   // Bus tasks
   // ****************************************
   task automatic results();
      $display("checks=%0d failures=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Classic cycle; a hung slave ends the run
   task automatic bus(input logic [3:0] a, input logic w,
                      input logic [31:0] d);
      int n;
      @(posedge clk_i);
      adr <= a; we <= w; wdat <= d; sel <= sel_v; cyc <= 1'b1; stb <= 1'b1;
      n = 0;
      // Answer looked at mid-cycle, request dropped at the next rise
      do begin
         @(negedge clk_i);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
      if (n >= 50) begin n_fail++; results(); end
      q = rdat;
      e = err;
      @(posedge clk_i);
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a); bus(a, 1'b0, 32'h0); endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
      repeat (2) @(posedge clk_i);
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      ulc_usb_partner_inst.lines(1'b1, 1'b0);
      rd(4'h0); `CHK(q, 32'h0000_0080)
      ulc_usb_partner_inst.lines(1'b0, 1'b1);
      rd(4'h0); `CHK(q, 32'h0000_0040)
      ulc_usb_partner_inst.lines(1'b0, 1'b0);
      wr(4'h0, 32'hFFFF_FFF7);
      rd(4'h0); `CHK(q, 32'h0000_0037)
      `CHK({brst, pkt, res, pp, den, sof}, 6'h3E)
      `CHK(hen, 1'b0)
      wr(4'h0, 32'h0);
      `CHK({brst, pkt, res, pp, den, eop, n_eop}, 38'h0)
      sel_v = 4'hE;
      wr(4'h0, 32'h0000_0003);
      sel_v = 4'hF;
      rd(4'h0); `CHK(q, 32'h0)
      rd(4'hC); `CHK(e, 1'b1)
      wr(4'h8, 32'h0);
      ulc_usb_partner_inst.pulse(0);
      repeat (2) @(posedge clk_i);
      `CHK({pkt, irq}, 2'b10)
      rd(4'h0); `CHK(q, 32'h0000_0020)
      rd(4'h4); `CHK(q[3:0], 4'h1)
      wr(4'h8, 32'h1); `CHK(irq, 1'b1)
      wr(4'h4, 32'h1); `CHK(irq, 1'b0)
      wr(4'h0, 32'h0); `CHK(pkt, 1'b0)
      wr(4'h0, 32'h8); `CHK({hen, n_hlr}, 33'h1_0000_0001)
      rd(4'h4); `CHK(q[3:0], 4'h4)
      wr(4'h4, 32'hF);
      ulc_usb_partner_inst.pulse(1);
      repeat (2) @(posedge clk_i);
      rd(4'h0); `CHK({busy, q}, 33'h1_0000_0028)
      ulc_usb_partner_inst.pulse(2);
      k = 0;
      do begin
         rd(4'h0);
         k++;
      end while (q[5] !== 1'b0 && k < 20);
      `CHK({busy, q}, 33'h0_0000_0008)
      rd(4'h4); `CHK(q[3:0], 4'h2)
      wr(4'h0, 32'h9); `CHK({sof, den}, 2'b10)
      wr(4'h0, 32'hD); `CHK(res, 1'b1)
      repeat (RES_HOLD) @(posedge clk_i);
      wr(4'h0, 32'h9);
      repeat (EOP + 4) @(posedge clk_i);
      `CHK({res, n_eop}, 33'd4)
      wr(4'h0, 32'h0); `CHK(n_hlr, 2)
      results();
   end
endmodule
